/* File: core/csp_clkdiv.sv */
// Bit clock divider with edge strobes
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
module csp_clkdiv
   import csp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Control
   input wire logic run,
   input wire logic [`CSP_DIV_W-1:0] mclk_div,
   input wire logic [`CSP_DIV_W-1:0] sclk_div,
   // Bit clock and strobes
   output logic bit_clk,
   output logic rise,
   output logic fall
);
   logic [`CSP_PROD_W-1:0] cnt;
   logic [`CSP_PROD_W-1:0] next_cnt;
   logic [`CSP_PROD_W-1:0] prod;
   logic next_bit_clk;
   logic next_rise;
   logic next_fall;

   // Period is the product of both dividers, but never less than CSP_MIN_PROD clocks
   always_comb begin
      prod = {3'h0, mclk_div} * {3'h0, sclk_div};
      if (prod < `CSP_MIN_PROD) begin
         prod = `CSP_MIN_PROD;
      end
      next_cnt = cnt;
      next_bit_clk = bit_clk;
      next_rise = 1'b0;
      next_fall = 1'b0;
      if (!run) begin
         next_cnt = '0;
         next_bit_clk = 1'b0;
      end else if (cnt == prod - 6'h01) begin
         next_cnt = '0;
         next_bit_clk = 1'b1;
         next_rise = 1'b1;
      end else begin
         next_cnt = cnt + 6'h01;
         if (cnt == (prod >> 1) - 6'h01) begin
            next_bit_clk = 1'b0;
            next_fall = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt <= '0;
         bit_clk <= 1'b0;
         rise <= 1'b0;
         fall <= 1'b0;
      end else begin
         cnt <= next_cnt;
         bit_clk <= next_bit_clk;
         rise <= next_rise;
         fall <= next_fall;
      end
   end
endmodule
`default_nettype wire

/* File: core/csp_defs.svh */
// Constants for the codec serial port
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH
`define CSP_WORD_W 16
`define CSP_CNT_W 4
`define CSP_LAST_BIT 4'hf
`define CSP_CTRL_FLAG 15
`define CSP_CHAN_SEL 8
`define CSP_HIREF_BIT 7
`define CSP_REGC_RST 8'h00
`define CSP_DIV_W 3
`define CSP_PROD_W 6
`define CSP_MIN_PROD 6'h02
`endif

/* File: core/csp_pkg.sv */
// Types for the codec serial port
package csp_pkg;
   typedef enum logic [1:0] {
      CSP_TX_IDLE = 2'b00,
      CSP_TX_SYNC = 2'b01,
      CSP_TX_SHIFT = 2'b11
   } csp_tx_state_t;
   typedef enum logic [1:0] {
      CSP_RX_IDLE = 2'b00,
      CSP_RX_SHIFT = 2'b01
   } csp_rx_state_t;
endpackage

/* File: core/csp_serial_port.sv */
// Codec serial port, device end
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
module csp_serial_port
   import csp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Link pins
   input wire logic link_enable,
   input wire logic rx_line,
   input wire logic rx_frame_sync,
   output logic bit_clk,
   output logic tx_line,
   output logic tx_line_oe,
   output logic tx_frame_sync,
   output logic tx_frame_sync_oe,
   // Divider settings
   input wire logic [`CSP_DIV_W-1:0] mclk_div,
   input wire logic [`CSP_DIV_W-1:0] sclk_div,
   // Outgoing words
   input wire logic [`CSP_WORD_W-1:0] tx_word,
   input wire logic tx_valid,
   output logic tx_taken,
   // Incoming words
   output logic [`CSP_WORD_W-1:0] rx_word,
   output logic rx_word_valid,
   // Reference level
   output logic high_ref_select
);
   logic en_meta, en;
   logic fs_meta, fs_s;
   logic rd_meta, rd_s;
   logic rise, fall;
   csp_tx_state_t tx_st, next_tx_st;
   csp_rx_state_t rx_st, next_rx_st;
   logic [`CSP_WORD_W-1:0] tx_sr, next_tx_sr;
   logic [`CSP_CNT_W-1:0] tx_cnt, next_tx_cnt;
   logic next_tx_line, next_tx_line_oe, next_tx_fs, next_tx_fs_oe, next_tx_taken;
   logic [`CSP_WORD_W-1:0] rx_sr, next_rx_sr, next_rx_word;
   logic [`CSP_CNT_W-1:0] rx_cnt, next_rx_cnt;
   logic next_rx_word_valid;
   logic [7:0] reg_c [2];
   logic [7:0] next_reg_c [2];
   logic next_high_ref;

   csp_clkdiv u_div (
      .clk_sys(clk_sys),
      .rst(rst),
      .run(en),
      .mclk_div(mclk_div),
      .sclk_div(sclk_div),
      .bit_clk(bit_clk),
      .rise(rise),
      .fall(fall)
   );

   // Pin synchronisers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         en_meta <= 1'b0;
         en <= 1'b0;
         fs_meta <= 1'b0;
         fs_s <= 1'b0;
         rd_meta <= 1'b0;
         rd_s <= 1'b0;
      end else begin
         en_meta <= link_enable;
         en <= en_meta;
         fs_meta <= rx_frame_sync;
         fs_s <= fs_meta;
         rd_meta <= rx_line;
         rd_s <= rd_meta;
      end
   end

   // Transmit side
   always_comb begin
      next_tx_st = tx_st;
      next_tx_sr = tx_sr;
      next_tx_cnt = tx_cnt;
      next_tx_line = tx_line;
      next_tx_line_oe = tx_line_oe;
      next_tx_fs = tx_frame_sync;
      next_tx_fs_oe = en;
      next_tx_taken = 1'b0;
      if (!en) begin
         next_tx_st = CSP_TX_IDLE;
         next_tx_cnt = '0;
         next_tx_fs = 1'b0;
         next_tx_line_oe = 1'b0;
         next_tx_line = 1'b0;
      // Everything moves on the rising edge
      end else if (rise) begin
         unique case (tx_st)
            CSP_TX_IDLE: begin
               next_tx_line_oe = 1'b0;
               // Sync one period ahead of the MSB
               if (tx_valid) begin
                  next_tx_st = CSP_TX_SYNC;
                  next_tx_sr = tx_word;
                  next_tx_fs = 1'b1;
                  next_tx_taken = 1'b1;
               end
            end
            CSP_TX_SYNC: begin
               next_tx_st = CSP_TX_SHIFT;
               next_tx_fs = 1'b0;
               next_tx_line_oe = 1'b1;
               next_tx_line = tx_sr[`CSP_WORD_W-1];
               next_tx_sr = {tx_sr[`CSP_WORD_W-2:0], 1'b0};
               next_tx_cnt = '0;
            end
            CSP_TX_SHIFT: begin
               if (tx_cnt == `CSP_LAST_BIT) begin
                  next_tx_line_oe = 1'b0;
                  next_tx_line = 1'b0;
                  if (tx_valid) begin
                     next_tx_st = CSP_TX_SYNC;
                     next_tx_sr = tx_word;
                     next_tx_fs = 1'b1;
                     next_tx_taken = 1'b1;
                  end else begin
                     next_tx_st = CSP_TX_IDLE;
                  end
               end else begin
                  next_tx_line = tx_sr[`CSP_WORD_W-1];
                  next_tx_sr = {tx_sr[`CSP_WORD_W-2:0], 1'b0};
                  next_tx_cnt = tx_cnt + 4'h1;
               end
            end
         endcase
      end
   end

   // Frame sync output enabled only with the link
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_st <= CSP_TX_IDLE;
         tx_sr <= '0;
         tx_cnt <= '0;
         tx_line <= 1'b0;
         tx_line_oe <= 1'b0;
         tx_frame_sync <= 1'b0;
         tx_frame_sync_oe <= 1'b0;
         tx_taken <= 1'b0;
      end else begin
         tx_st <= next_tx_st;
         tx_sr <= next_tx_sr;
         tx_cnt <= next_tx_cnt;
         tx_line <= next_tx_line;
         tx_line_oe <= next_tx_line_oe;
         tx_frame_sync <= next_tx_fs;
         tx_frame_sync_oe <= next_tx_fs_oe;
         tx_taken <= next_tx_taken;
      end
   end

   // Receive side and control registers
   always_comb begin
      next_rx_st = rx_st;
      next_rx_sr = rx_sr;
      next_rx_cnt = rx_cnt;
      next_rx_word = rx_word;
      next_rx_word_valid = 1'b0;
      next_reg_c[0] = reg_c[0];
      next_reg_c[1] = reg_c[1];
      if (!en) begin
         next_rx_st = CSP_RX_IDLE;
         next_rx_cnt = '0;
      end else if (fall) begin
         unique case (rx_st)
            CSP_RX_IDLE: begin
               // Host sync marks the next bit as MSB
               if (fs_s) begin
                  next_rx_st = CSP_RX_SHIFT;
                  next_rx_cnt = '0;
               end
            end
            CSP_RX_SHIFT: begin
               // Data captured on the falling edge
               next_rx_sr = {rx_sr[`CSP_WORD_W-2:0], rd_s};
               next_rx_cnt = rx_cnt + 4'h1;
               if (rx_cnt == `CSP_LAST_BIT) begin
                  next_rx_st = CSP_RX_IDLE;
                  next_rx_word = next_rx_sr;
                  next_rx_word_valid = 1'b1;
                  if (next_rx_sr[`CSP_CTRL_FLAG]) begin
                     next_reg_c[next_rx_sr[`CSP_CHAN_SEL]] = next_rx_sr[7:0];
                  end
               end
            end
            default: begin
               next_rx_st = CSP_RX_IDLE;
            end
         endcase
      end
      next_high_ref = next_reg_c[0][`CSP_HIREF_BIT] | next_reg_c[1][`CSP_HIREF_BIT];
   end

   // Reset clears every register including control
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_st <= CSP_RX_IDLE;
         rx_sr <= '0;
         rx_cnt <= '0;
         rx_word <= '0;
         rx_word_valid <= 1'b0;
         reg_c[0] <= `CSP_REGC_RST;
         reg_c[1] <= `CSP_REGC_RST;
         high_ref_select <= 1'b0;
      end else begin
         rx_st <= next_rx_st;
         rx_sr <= next_rx_sr;
         rx_cnt <= next_rx_cnt;
         rx_word <= next_rx_word;
         rx_word_valid <= next_rx_word_valid;
         reg_c[0] <= next_reg_c[0];
         reg_c[1] <= next_reg_c[1];
         high_ref_select <= next_high_ref;
      end
   end
endmodule
`default_nettype wire

/* File: verif/csp_host_model.sv */
// Host processor side of the codec serial port
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
module csp_host_model (
   // Link pins
   input wire logic bit_clk,
   input wire logic tx_pin,
   input wire logic tx_fs_pin,
   output logic rx_line,
   output logic rx_frame_sync,
   // Test control
   input wire logic [`CSP_WORD_W-1:0] send_word,
   input wire logic send_go,
   output logic [`CSP_WORD_W-1:0] got_word,
   output logic got_pulse
);
   int n = 0;
   int m = 0;
   logic [`CSP_WORD_W-1:0] sh = 0;
   logic [`CSP_WORD_W-1:0] rsh = 0;
   initial begin
      rx_line = 0;
      rx_frame_sync = 0;
      got_word = 0;
      got_pulse = 0;
   end
   always @(posedge bit_clk) begin
      rx_frame_sync <= send_go && n == 0;
      if (send_go && n == 0) begin
         sh <= send_word;
         n <= 16;
      end else if (n > 0) begin
         rx_line <= sh[15];
         sh <= sh << 1;
         n <= n - 1;
      end else begin
         rx_line <= ~rx_line;
      end
   end
   always @(negedge bit_clk) begin
      got_pulse <= 0;
      if (m > 0) begin
         rsh <= {rsh[14:0], tx_pin};
         m <= m - 1;
      end
      if (m == 1) begin
         got_word <= {rsh[14:0], tx_pin};
         got_pulse <= 1;
      end
      if (tx_fs_pin === 1'b1) m <= 16;
   end
endmodule
`default_nettype wire

/* File: verif/csp_properties.sv */
// Checker of the codec serial port pins
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
module csp_properties
   import csp_pkg::*;
(
   // Watched ports
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic bit_clk,
   input wire logic tx_line,
   input wire logic tx_line_oe,
   input wire logic tx_frame_sync,
   input wire logic tx_frame_sync_oe,
   input wire logic tx_taken,
   input wire logic rx_word_valid
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   taken_sync_a: assert property (tx_taken |-> $rose(tx_frame_sync)) else $error("take without sync");
   sync_edge_a: assert property ($rose(tx_frame_sync) |-> $past(bit_clk) && !$past(bit_clk, 2))
      else $error("sync off edge");
   data_edge_a: assert property (tx_line_oe && $past(tx_line_oe) && $changed(tx_line) |->
      $past(bit_clk) && !$past(bit_clk, 2)) else $error("data off edge");
   off_float_a: assert property (!tx_frame_sync_oe |-> !tx_line_oe) else $error("line driven while off");
   sync_float_a: assert property (tx_frame_sync |-> !tx_line_oe) else $error("line driven in sync");
   msb_follow_a: assert property ($fell(tx_frame_sync) && tx_frame_sync_oe |-> tx_line_oe)
      else $error("no bit after sync");
   rx_pulse_a: assert property (rx_word_valid |=> !rx_word_valid) else $error("long word pulse");
   clk_stop_a: assert property (!tx_frame_sync_oe [*3] |-> !bit_clk && !tx_line_oe)
      else $error("clock runs while off");
endmodule
bind csp_serial_port csp_properties csp_properties_i (.clk_sys, .rst, .bit_clk, .tx_line, .tx_line_oe,
   .tx_frame_sync, .tx_frame_sync_oe, .tx_taken, .rx_word_valid);
`default_nettype wire

/* File: verif/csp_serial_port_tb.sv */
// Testbench of the codec serial port
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
module csp_serial_port_tb import csp_pkg::*;;
   logic clk_sys = 0, rst = 1, link_enable = 0, tx_valid = 0, go = 0;
   logic rx_line, rx_frame_sync, bit_clk, tx_line, tx_line_oe, tx_frame_sync, tx_frame_sync_oe;
   logic tx_taken, rx_word_valid, high_ref_select, got_pulse;
   logic [`CSP_WORD_W-1:0] tx_word = 0, rx_word, send_word = 0, got_word;
   logic [`CSP_DIV_W-1:0] mclk_div = 3'h4;
   logic [`CSP_DIV_W-1:0] sclk_div = 3'h4;
   int err_total = 0, checks_done = 0;
   wire tx_pin = tx_line_oe ? tx_line : 1'bz;
   wire fs_pin = tx_frame_sync_oe ? tx_frame_sync : 1'bz;
   always #2 clk_sys = ~clk_sys;
   csp_serial_port csp_serial_port_i (.clk_sys, .rst, .link_enable, .rx_line, .rx_frame_sync, .bit_clk,
      .tx_line, .tx_line_oe, .tx_frame_sync, .tx_frame_sync_oe, .mclk_div, .sclk_div, .tx_word,
      .tx_valid, .tx_taken, .rx_word, .rx_word_valid, .high_ref_select);
   csp_host_model csp_host_model_i (.bit_clk, .tx_pin, .tx_fs_pin(fs_pin), .send_word, .send_go(go),
      .rx_line, .rx_frame_sync, .got_word, .got_pulse);
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_hi(ref logic s);
      for (int k = 0; k < 4000 && s !== 1'b1; k++) @(negedge clk_sys);
      if (s !== 1'b1) begin
         check("wait", 16'h0, 16'h1);
      end
   endtask
   task automatic send_rx(logic [15:0] w);
      send_word = w;
      go = 1;
      wait_hi(rx_frame_sync);
      go = 0;
      wait_hi(rx_word_valid);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic t_reset();
      repeat (20) @(negedge clk_sys);
      check("reset", {bit_clk, tx_line_oe, tx_frame_sync_oe, tx_taken, rx_word_valid, high_ref_select}, 0);
      rst = 0;
      link_enable = 1;
   endtask
   task automatic t_clock();
      int n = 0;
      while (bit_clk !== 1'b1) @(negedge clk_sys);
      while (bit_clk === 1'b1) begin n++; @(negedge clk_sys); end
      while (bit_clk === 1'b0 && n < 99) begin n++; @(negedge clk_sys); end
      check("period", n, 16);
   endtask
   task automatic t_tx();
      tx_word = 16'ha5c3;
      tx_valid = 1;
      wait_hi(tx_taken);
      tx_word = 16'h3c5a;
      @(negedge clk_sys);
      wait_hi(got_pulse);
      check("tx 1", got_word, 16'ha5c3);
      wait_hi(tx_taken);
      tx_valid = 0;
      while (got_pulse === 1'b1) @(negedge clk_sys);
      wait_hi(got_pulse);
      check("tx 2", got_word, 16'h3c5a);
      repeat (40) @(negedge clk_sys);
      check("idle oe", tx_line_oe, 0);
   endtask
   task automatic t_rx();
      logic [15:0] cw [5] = '{16'h8080, 16'h8180, 16'h8000, 16'h8100, 16'h8180};
      logic hr [5] = '{1, 1, 1, 0, 1};
      send_rx(16'h1234);
      check("rx", rx_word, 16'h1234);
      check("ref data", high_ref_select, 0);
      foreach (cw[i]) begin
         send_rx(cw[i]);
         repeat (2) @(negedge clk_sys);
         check("ref", high_ref_select, hr[i]);
      end
   endtask
   task automatic t_enable();
      tx_word = 16'hc00c;
      tx_valid = 1;
      wait_hi(tx_taken);
      tx_word = 16'h6699;
      repeat (80) @(negedge clk_sys);
      link_enable = 0;
      repeat (8) @(negedge clk_sys);
      check("off pins", {tx_line_oe, tx_frame_sync_oe, bit_clk}, 0);
      link_enable = 1;
      wait_hi(tx_taken);
      tx_valid = 0;
      wait_hi(got_pulse);
      check("tx on", got_word, 16'h6699);
      send_rx(16'h0f0f);
      check("rx on", rx_word, 16'h0f0f);
      check("ref kept", high_ref_select, 1);
   endtask
   // Reset in mid run clears control
   task automatic t_rereset();
      rst = 1;
      repeat (2) @(negedge clk_sys);
      check("reset ref", high_ref_select, 0);
      rst = 0;
      repeat (4) @(negedge clk_sys);
      check("after reset", {bit_clk, tx_line_oe, tx_frame_sync, high_ref_select}, 0);
   endtask
   task automatic t_divide();
      int hi = 0;
      int lo = 0;
      link_enable = 0;
      repeat (8) @(negedge clk_sys);
      mclk_div = 3'h1;
      sclk_div = 3'h1;
      link_enable = 1;
      for (int k = 0; k < 99 && bit_clk !== 1'b1; k++) @(negedge clk_sys);
      while (bit_clk === 1'b1 && hi < 99) begin
         hi++;
         @(negedge clk_sys);
      end
      while (bit_clk === 1'b0 && lo < 99) begin
         lo++;
         @(negedge clk_sys);
      end
      check("high phase", hi, 1);
      check("short period", hi + lo, 2);
   endtask
   initial begin
      t_reset();
      t_clock();
      t_tx();
      t_rx();
      t_enable();
      t_rereset();
      t_divide();
      finish_test();
   end
   initial begin
      #100000;
      err_total++;
      finish_test();
   end
endmodule
`default_nettype wire
